//--- verilog/cdr_pkg.sv
// constants for the counter-mode extended diagnostic record (sixteen bytes)
// assumes one module clock; all byte offsets are byte indices into the record
package cdr_pkg;

  // record layout
  localparam int unsigned REC_BYTES      = 16;
  localparam int unsigned BASIC_BYTES    = 4;
  localparam int unsigned ADDR_W         = 4;

  // byte offsets of the record
  localparam logic [3:0]  OFS_BASIC0     = 4'h0;
  localparam logic [3:0]  OFS_BASIC1     = 4'h1;
  localparam logic [3:0]  OFS_BASIC2     = 4'h2;
  localparam logic [3:0]  OFS_BASIC3     = 4'h3;
  localparam logic [3:0]  OFS_CHAN_TYPE  = 4'h4;
  localparam logic [3:0]  OFS_DIAG_BITS  = 4'h5;
  localparam logic [3:0]  OFS_CHAN_CNT   = 4'h6;
  localparam logic [3:0]  OFS_GRP_ERR    = 4'h7;
  localparam logic [3:0]  OFS_IN_LOST_A  = 4'h8;
  localparam logic [3:0]  OFS_IN_LOST_B  = 4'h9;
  localparam logic [3:0]  OFS_IN_LOST_C  = 4'ha;
  localparam logic [3:0]  OFS_IN_LOST_D  = 4'hb;
  localparam logic [3:0]  OFS_CNT0_LOST  = 4'hc;
  localparam logic [3:0]  OFS_CNT1_LOST  = 4'hd;
  localparam logic [3:0]  OFS_CNT2_LOST  = 4'he;
  localparam logic [3:0]  OFS_CNT3_LOST  = 4'hf;

  // fixed contents
  localparam logic [6:0]  CHAN_TYPE_DIN  = 7'h70;
  localparam logic [6:0]  CHAN_TYPE_AIN  = 7'h71;
  localparam logic [6:0]  CHAN_TYPE_DOUT = 7'h72;
  localparam logic [6:0]  CHAN_TYPE_AOUT = 7'h73;
  localparam logic [6:0]  CHAN_TYPE_AIO  = 7'h74;
  localparam logic [7:0]  DIAG_BITS_VAL  = 8'h08;
  localparam logic [7:0]  CHAN_CNT_VAL   = 8'h08;

  // field positions
  localparam int unsigned MORE_TYPES_BIT = 7;
  localparam int unsigned LOST_SUM_BIT   = 6;
  localparam int unsigned EV_GATE_CLOSE  = 0;
  localparam int unsigned EV_GATE_OPEN   = 1;
  localparam int unsigned EV_OVF_END     = 2;
  localparam int unsigned EV_COMPARE     = 3;

  // widths of the event sources
  localparam int unsigned N_INPUTS       = 16;
  localparam int unsigned N_COUNTERS     = 4;
  localparam int unsigned EV_PER_CNT     = 4;

  // reset values
  localparam logic [7:0]  BYTE_RST       = 8'h00;
  localparam logic [31:0] BASIC_RST      = 32'h0000_0000;

  // read port sequencing
  typedef enum logic [0:0] {
    CDR_RD_IDLE = 1'b0,
    CDR_RD_DONE = 1'b1
  } cdr_rd_state_t;

endpackage

//--- verilog/cdr_lost_acc.sv
// sticky accumulator of lost process interrupts, one bit per event source
// assumes evt and busy are synchronous strobes/levels from the event logic
module cdr_lost_acc #(
  parameter int unsigned N = 16
) (
  input  wire logic         clk,   // module clock
  input  wire logic         rst,   // sync reset, active high
  input  wire logic         ce,    // clock enable
  input  wire logic [N-1:0] evt,   // event strobe per source
  input  wire logic [N-1:0] busy,  // its process interrupt still handled
  input  wire logic         take,  // record capture restarts the set from that cycle's losses
  output logic      [N-1:0] acc    // accumulated lost flags
);

  logic [N-1:0] acc_ff;
  logic [N-1:0] nxt_acc;
  logic [N-1:0] lost_now;

  assign lost_now = evt & busy;
  // set wins over the clear so a loss in the capture cycle is kept
  assign nxt_acc  = (take ? '0 : acc_ff) | lost_now;
  assign acc      = acc_ff;

  // accumulator flops
  always_ff @(posedge clk) begin
    if (rst) begin
      acc_ff <= '0;
    end else if (ce) begin
      acc_ff <= nxt_acc;
    end
  end

  a_loss_sets_bit : assert property (@(posedge clk) disable iff (rst)
    (!rst && ce && lost_now != '0) |=> ((acc_ff & $past(lost_now)) == $past(lost_now)))
    else $error("lost event not accumulated");

  // capture restarts the set, keeping only losses of that cycle
  a_acc_restart : assert property (@(posedge clk) disable iff (rst)
    (!rst && ce && take) |=> acc_ff == $past(lost_now))
    else $error("capture did not restart the loss set");

endmodule

//--- verilog/cdr_record.sv
// counter-mode extended diagnostic record: capture, hold and byte readout
// assumes synchronous inputs; diag_evt is a one-cycle strobe per diagnostic event
// Behaviour
// - record is sixteen bytes: four basic bytes then twelve specific bytes
// - bytes zero to three repeat the basic record of the same event
// - byte four bits six to zero hold channel type, here digital input
// - byte four bit seven tells whether further channel types follow
// - byte five reports eight diagnostic bits per channel
// - byte six reports eight channels
// - byte seven bits zero to three flag errors in input nibble groups
// - byte seven bits four to seven flag errors in counters zero to three
// - bytes eight to eleven hold input lost flags on even bits only
// - counter byte bit zero marks lost gate-closing interrupt
// - counter byte bit two marks lost gate-opening interrupt
// - counter byte bit four marks lost overflow, underflow or end value
// - counter byte bit six marks lost compare; odd bits read zero
// - bytes twelve to fifteen belong to counters zero to three
// - loss arises when an event recurs while its interrupt is handled
// - byte three bit six shows that a process interrupt was lost
module cdr_record #(
  parameter logic [6:0] CHAN_TYPE  = cdr_pkg::CHAN_TYPE_DIN,  // channel type code
  parameter logic       MORE_TYPES = 1'b0                     // more types follow
) (
  input  wire logic        clk,        // module clock, 40 MHz
  input  wire logic        rst,        // sync reset, active high
  input  wire logic        ce,         // clock enable, freezes all state
  input  wire logic        diag_evt,   // diagnostic event strobe, captures record
  input  wire logic [31:0] basic_rec,  // basic record bytes 0..3, byte 0 low
  input  wire logic [7:0]  grp_err,    // group error levels, bit per group
  input  wire logic [15:0] din_evt,    // input edge event strobes
  input  wire logic [15:0] din_busy,   // input process interrupt pending
  input  wire logic [15:0] cnt_evt,    // counter events, 4 per counter
  input  wire logic [15:0] cnt_busy,   // counter process interrupt pending
  input  wire logic        rd_req,     // record byte read request
  input  wire logic [3:0]  rd_addr,    // record byte index
  output logic      [7:0]  rd_data,    // read byte, held until next read
  output logic             rd_valid,   // one cycle after a taken request
  output logic             lost_any    // captured record holds a loss
);

  // captured record state
  logic [31:0] basic_ff;
  logic [7:0]  err_ff;
  logic [15:0] din_lost_ff;
  logic [15:0] cnt_lost_ff;
  logic        lost_any_ff;
  logic [7:0]  rd_data_ff;
  logic        rd_valid_ff;
  logic [3:0]  rd_addr_ff;
  cdr_pkg::cdr_rd_state_t rd_state_ff;

  // next values
  logic [31:0] nxt_basic;
  logic [7:0]  nxt_err;
  logic [15:0] nxt_din_lost;
  logic [15:0] nxt_cnt_lost;
  logic        nxt_lost_any;
  logic [7:0]  nxt_rd_data;
  cdr_pkg::cdr_rd_state_t nxt_rd_state;

  // accumulated losses since the last capture
  logic [15:0] din_acc;
  logic [15:0] cnt_acc;
  logic        take;
  wire  [15:0] din_lost_now = din_evt & din_busy;
  wire  [15:0] cnt_lost_now = cnt_evt & cnt_busy;

  // places four flags on the even bits of a byte, odd bits stay zero
  function automatic logic [7:0] spread4(input logic [3:0] f);
    spread4 = {1'b0, f[3], 1'b0, f[2], 1'b0, f[1], 1'b0, f[0]};
  endfunction

  // picks byte k of a 32-bit word
  function automatic logic [7:0] byte_of(input logic [31:0] w, input logic [1:0] k);
    byte_of = w[{k, 3'b000} +: 8];
  endfunction

  cdr_lost_acc #(
    .N (cdr_pkg::N_INPUTS)
  ) u_din_acc (
    .clk  (clk),
    .rst  (rst),
    .ce   (ce),
    .evt  (din_evt),
    .busy (din_busy),
    .take (take),
    .acc  (din_acc)
  );

  cdr_lost_acc #(
    .N (cdr_pkg::N_COUNTERS * cdr_pkg::EV_PER_CNT)
  ) u_cnt_acc (
    .clk  (clk),
    .rst  (rst),
    .ce   (ce),
    .evt  (cnt_evt),
    .busy (cnt_busy),
    .take (take),
    .acc  (cnt_acc)
  );

  assign take = diag_evt;
  // losses in the capture cycle itself join this record, as they raise it
  assign nxt_din_lost = take ? (din_acc | din_lost_now) : din_lost_ff;
  assign nxt_cnt_lost = take ? (cnt_acc | cnt_lost_now) : cnt_lost_ff;
  assign nxt_err      = take ? grp_err : err_ff;
  assign nxt_lost_any = take ? ((|nxt_din_lost) | (|nxt_cnt_lost)) : lost_any_ff;

  // basic bytes repeated, loss summary in byte three bit six
  assign nxt_basic = take ?
    {basic_rec[31], nxt_lost_any, basic_rec[29:0]} : basic_ff;

  // byte selection of the record
  logic [7:0] sel_byte;
  always_comb begin
    sel_byte = cdr_pkg::BYTE_RST;
    case (rd_addr)
      cdr_pkg::OFS_BASIC0,
      cdr_pkg::OFS_BASIC1,
      cdr_pkg::OFS_BASIC2,
      cdr_pkg::OFS_BASIC3:     sel_byte = byte_of(basic_ff, rd_addr[1:0]);
      cdr_pkg::OFS_CHAN_TYPE:  sel_byte = {MORE_TYPES, CHAN_TYPE};
      cdr_pkg::OFS_DIAG_BITS:  sel_byte = cdr_pkg::DIAG_BITS_VAL;
      cdr_pkg::OFS_CHAN_CNT:   sel_byte = cdr_pkg::CHAN_CNT_VAL;
      cdr_pkg::OFS_GRP_ERR:    sel_byte = err_ff;
      cdr_pkg::OFS_IN_LOST_A:  sel_byte = spread4(din_lost_ff[3:0]);
      cdr_pkg::OFS_IN_LOST_B:  sel_byte = spread4(din_lost_ff[7:4]);
      cdr_pkg::OFS_IN_LOST_C:  sel_byte = spread4(din_lost_ff[11:8]);
      cdr_pkg::OFS_IN_LOST_D:  sel_byte = spread4(din_lost_ff[15:12]);
      cdr_pkg::OFS_CNT0_LOST:  sel_byte = spread4(cnt_lost_ff[3:0]);
      cdr_pkg::OFS_CNT1_LOST:  sel_byte = spread4(cnt_lost_ff[7:4]);
      cdr_pkg::OFS_CNT2_LOST:  sel_byte = spread4(cnt_lost_ff[11:8]);
      cdr_pkg::OFS_CNT3_LOST:  sel_byte = spread4(cnt_lost_ff[15:12]);
      default:                 sel_byte = cdr_pkg::BYTE_RST;
    endcase
  end

  // read path only samples, never writes the record
  assign nxt_rd_data  = rd_req ? sel_byte : rd_data_ff;
  assign nxt_rd_state = rd_req ? cdr_pkg::CDR_RD_DONE : cdr_pkg::CDR_RD_IDLE;

  // record capture flops
  // hold until next event
  always_ff @(posedge clk) begin
    if (rst) begin
      basic_ff    <= cdr_pkg::BASIC_RST;
      err_ff      <= cdr_pkg::BYTE_RST;
      din_lost_ff <= '0;
      cnt_lost_ff <= '0;
      lost_any_ff <= 1'b0;
    end else if (ce) begin
      basic_ff    <= nxt_basic;
      err_ff      <= nxt_err;
      din_lost_ff <= nxt_din_lost;
      cnt_lost_ff <= nxt_cnt_lost;
      lost_any_ff <= nxt_lost_any;
    end
  end

  // read port flops; one-cycle answer keeps software timing fixed
  always_ff @(posedge clk) begin
    if (rst) begin
      rd_state_ff <= cdr_pkg::CDR_RD_IDLE;
      rd_data_ff  <= cdr_pkg::BYTE_RST;
      rd_addr_ff  <= '0;
    end else if (ce) begin
      rd_state_ff <= nxt_rd_state;
      rd_data_ff  <= nxt_rd_data;
      if (rd_req) begin
        rd_addr_ff <= rd_addr;
      end
    end
  end

  // valid pulse from the read state
  always_comb begin
    case (rd_state_ff)
      cdr_pkg::CDR_RD_IDLE: rd_valid_ff = 1'b0;
      cdr_pkg::CDR_RD_DONE: rd_valid_ff = 1'b1;
      default:              rd_valid_ff = 1'b0;
    endcase
  end

  // outputs straight from flops
  assign rd_data  = rd_data_ff;
  assign rd_valid = rd_valid_ff;
  assign lost_any = lost_any_ff;

  // checks

  // read taken; a reset edge is no request
  sequence s_read_taken;
    !rst && ce && rd_req;
  endsequence

  sequence s_capture;
    !rst && ce && take;
  endsequence

  // read without capture, so the record still stands next cycle
  sequence s_quiet_read;
    !rst && ce && rd_req && !take;
  endsequence

  a_read_answer : assert property (@(posedge clk) disable iff (rst)
    s_read_taken |=> rd_valid && rd_addr_ff == $past(rd_addr))
    else $error("read request not answered in one cycle");

  a_valid_pulse : assert property (@(posedge clk) disable iff (rst)
    (!rst && ce && !rd_req) |=> !rd_valid)
    else $error("read answer without request");

  a_type_byte : assert property (@(posedge clk) disable iff (rst)
    (rd_valid && rd_addr_ff == cdr_pkg::OFS_CHAN_TYPE) |->
      rd_data == {MORE_TYPES, CHAN_TYPE})
    else $error("channel type byte wrong");

  a_more_types_bit : assert property (@(posedge clk) disable iff (rst)
    (rd_valid && rd_addr_ff == cdr_pkg::OFS_CHAN_TYPE) |->
      rd_data[cdr_pkg::MORE_TYPES_BIT] == MORE_TYPES)
    else $error("continuation bit wrong");

  a_fixed_counts : assert property (@(posedge clk) disable iff (rst)
    (rd_valid && (rd_addr_ff == cdr_pkg::OFS_DIAG_BITS ||
                  rd_addr_ff == cdr_pkg::OFS_CHAN_CNT)) |-> rd_data == 8'h08)
    else $error("bits or channel count byte wrong");

  a_odd_bits_zero : assert property (@(posedge clk) disable iff (rst)
    (rd_valid && rd_addr_ff >= cdr_pkg::OFS_IN_LOST_A) |-> (rd_data & 8'haa) == 8'h00)
    else $error("odd bit set in loss byte");

  a_error_capture : assert property (@(posedge clk) disable iff (rst)
    s_capture |=> err_ff == $past(grp_err))
    else $error("group errors not captured");

  a_grp_input_err : assert property (@(posedge clk) disable iff (rst)
    s_quiet_read ##0 (rd_addr == cdr_pkg::OFS_GRP_ERR) |=> rd_data[3:0] == err_ff[3:0])
    else $error("input group error bits wrong");

  a_grp_counter_err : assert property (@(posedge clk) disable iff (rst)
    s_quiet_read ##0 (rd_addr == cdr_pkg::OFS_GRP_ERR) |=> rd_data[7:4] == err_ff[7:4])
    else $error("counter error bits wrong");

  // record holds; a reset edge is excluded, it empties the record
  a_record_hold : assert property (@(posedge clk) disable iff (rst)
    (!rst && (!take || !ce)) |=>
      $stable(err_ff) && $stable(din_lost_ff) && $stable(cnt_lost_ff))
    else $error("record changed without diagnostic event");

  // clock enable low freezes the outputs
  a_freeze_outputs : assert property (@(posedge clk) disable iff (rst)
    (!rst && !ce) |=> $stable(rd_data) && $stable(rd_valid) && $stable(lost_any))
    else $error("outputs moved while clock enable low");

  a_input_byte_a : assert property (@(posedge clk) disable iff (rst)
    s_quiet_read ##0 (rd_addr == cdr_pkg::OFS_IN_LOST_A) |=>
      rd_data[0] == din_lost_ff[0] && rd_data[2] == din_lost_ff[1] &&
      rd_data[4] == din_lost_ff[2] && rd_data[6] == din_lost_ff[3])
    else $error("first input loss byte wrong");

  a_input_byte_d : assert property (@(posedge clk) disable iff (rst)
    s_quiet_read ##0 (rd_addr == cdr_pkg::OFS_IN_LOST_D) |=>
      rd_data[0] == din_lost_ff[12] && rd_data[2] == din_lost_ff[13] &&
      rd_data[4] == din_lost_ff[14] && rd_data[6] == din_lost_ff[15])
    else $error("last input loss byte wrong");

  a_gate_close_lost : assert property (@(posedge clk) disable iff (rst)
    s_quiet_read ##0 (rd_addr == cdr_pkg::OFS_CNT1_LOST) |=>
      rd_data[0] == cnt_lost_ff[4 + cdr_pkg::EV_GATE_CLOSE])
    else $error("gate closing loss bit wrong");

  a_gate_open_lost : assert property (@(posedge clk) disable iff (rst)
    s_quiet_read ##0 (rd_addr == cdr_pkg::OFS_CNT2_LOST) |=>
      rd_data[2] == cnt_lost_ff[8 + cdr_pkg::EV_GATE_OPEN])
    else $error("gate opening loss bit wrong");

  // overflow or end value, counter three
  a_overflow_lost : assert property (@(posedge clk) disable iff (rst)
    s_quiet_read ##0 (rd_addr == cdr_pkg::OFS_CNT3_LOST) |=>
      rd_data[4] == cnt_lost_ff[12 + cdr_pkg::EV_OVF_END])
    else $error("overflow loss bit wrong");

  // counter zero byte; capture in the read cycle would shift the record
  a_cnt0_compare : assert property (@(posedge clk) disable iff (rst)
    s_quiet_read ##0 (rd_addr == cdr_pkg::OFS_CNT0_LOST) |=>
      rd_data[6] == cnt_lost_ff[cdr_pkg::EV_COMPARE] &&
      rd_data[0] == cnt_lost_ff[cdr_pkg::EV_GATE_CLOSE])
    else $error("counter zero byte mismatch");

  // loss in the capture cycle raises the summary
  a_capture_loss : assert property (@(posedge clk) disable iff (rst)
    s_capture ##0 (din_lost_now != '0 || cnt_lost_now != '0) |=> lost_any)
    else $error("capture cycle loss not reported");

  a_loss_summary : assert property (@(posedge clk) disable iff (rst)
    s_capture ##1 1'b1 |-> basic_ff[24 + cdr_pkg::LOST_SUM_BIT] == lost_any_ff &&
      lost_any_ff == ((|din_lost_ff) | (|cnt_lost_ff)))
    else $error("loss summary bit inconsistent");

  // summary bit read in byte three
  a_summary_read : assert property (@(posedge clk) disable iff (rst)
    s_quiet_read ##0 (rd_addr == cdr_pkg::OFS_BASIC3) |=>
      rd_data[cdr_pkg::LOST_SUM_BIT] == lost_any_ff)
    else $error("summary bit in byte three wrong");

  a_basic_copy : assert property (@(posedge clk) disable iff (rst)
    s_capture |=> basic_ff[29:0] == $past(basic_rec[29:0]))
    else $error("basic record bytes not repeated");

  a_basic_byte_zero : assert property (@(posedge clk) disable iff (rst)
    s_quiet_read ##0 (rd_addr == cdr_pkg::OFS_BASIC0) |=> rd_data == basic_ff[7:0])
    else $error("basic byte zero wrong");

  a_read_no_effect : assert property (@(posedge clk) disable iff (rst)
    (s_read_taken and !take) |=> $stable(din_lost_ff) && $stable(basic_ff))
    else $error("read disturbed the record");

  // loss one cycle ahead of a capture lands in the record
  a_loss_reaches_record : assert property (@(posedge clk) disable iff (rst)
    (!rst && ce && din_lost_now != '0) ##1 s_capture |=>
      (din_lost_ff & $past(din_lost_now, 2)) == $past(din_lost_now, 2))
    else $error("input loss missing from record");

endmodule

//--- test/cdr_testbench.sv
// self-checking bench for the counter-mode extended diagnostic record
// assumes cdr_pkg and cdr_record are compiled first; one 40 MHz clock
module testbench;
  timeunit 1ns;
  timeprecision 100ps;

  logic        clk;        // module clock
  logic        rst;        // sync reset
  logic        ce;         // clock enable
  logic        diag_evt;   // capture strobe
  logic [31:0] basic_rec;  // basic record bytes
  logic [7:0]  grp_err;    // group error levels
  logic [15:0] din_evt;    // input event strobes
  logic [15:0] din_busy;   // input interrupt pending
  logic [15:0] cnt_evt;    // counter event strobes
  logic [15:0] cnt_busy;   // counter interrupt pending
  logic        rd_req;     // read request
  logic [3:0]  rd_addr;    // byte index
  logic [7:0]  rd_data;    // read byte
  logic        rd_valid;   // read answer
  logic        lost_any;   // loss summary

  // bench state: reference record, loss accumulators, scoreboard
  logic [31:0] rs;
  logic [31:0] r_basic;
  logic [7:0]  r_grp;
  logic [15:0] r_din;
  logic [15:0] r_cnt;
  logic [15:0] acc_d;
  logic [15:0] acc_c;
  logic        live;
  logic        quiet;
  logic [11:0] notes[$];
  int          err_total;
  int          checked;

  cdr_record #(
    .CHAN_TYPE  (cdr_pkg::CHAN_TYPE_DIN),
    .MORE_TYPES (1'b0)
  ) dut (
    .clk       (clk),
    .rst       (rst),
    .ce        (ce),
    .diag_evt  (diag_evt),
    .basic_rec (basic_rec),
    .grp_err   (grp_err),
    .din_evt   (din_evt),
    .din_busy  (din_busy),
    .cnt_evt   (cnt_evt),
    .cnt_busy  (cnt_busy),
    .rd_req    (rd_req),
    .rd_addr   (rd_addr),
    .rd_data   (rd_data),
    .rd_valid  (rd_valid),
    .lost_any  (lost_any)
  );

  always #12.5 clk = ~clk;

  function automatic logic [31:0] xrand();
    rs = rs ^ (rs << 13);
    rs = rs ^ (rs >> 17);
    rs = rs ^ (rs << 5);
    return rs;
  endfunction

  // expected byte from the reference record; odd bits of loss bytes stay zero
  function automatic logic [7:0] exp_byte(input logic [3:0] a);
    logic [7:0] b;
    int         k;
    b = 8'h00;
    if (a < 4'h4) b = r_basic[8*a +: 8];
    if (a == 4'h3) b[6] = |{r_din, r_cnt};
    if (a == 4'h4) b = 8'h70;
    if (a == 4'h5 || a == 4'h6) b = 8'h08;
    if (a == 4'h7) b = r_grp;
    for (k = 0; k < 4; k++) begin
      if (a >= 4'h8 && a < 4'hc) b[2*k] = r_din[4*(a-8)+k];
      if (a >= 4'hc) b[2*k] = r_cnt[4*(a-12)+k];
    end
    return b;
  endfunction

  task automatic check_val(input string name, input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      err_total++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic stop_test();
    $display("checks %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // reference model, sees the values the design samples at this edge
  always @(posedge clk) begin
    logic [15:0] ld;
    logic [15:0] lc;
    if (live) check_val("lost_any", {7'h00, lost_any}, {7'h00, |{r_din, r_cnt}});
    ld = din_evt & din_busy;
    lc = cnt_evt & cnt_busy;
    if (rst) begin
      {r_basic, r_grp, r_din, r_cnt, acc_d, acc_c} = '0;
      live <= 1'b1;
    end else if (ce) begin
      if (rd_req) notes.push_back({rd_addr, exp_byte(rd_addr)});
      // loss in the capture cycle lands in this record and in the next
      if (diag_evt) begin
        r_basic = basic_rec;
        r_grp   = grp_err;
        r_din   = acc_d | ld;
        r_cnt   = acc_c | lc;
        acc_d   = ld;
        acc_c   = lc;
      end else begin
        acc_d = acc_d | ld;
        acc_c = acc_c | lc;
      end
    end
  end

  // monitor: each answered read takes the oldest note
  always @(posedge clk) begin
    logic [11:0] n;
    if (live && ce === 1'b1 && rd_valid === 1'b1) begin
      if (notes.size() == 0) begin
        err_total++;
        $display("BAD rd_valid expected 0 seen 1");
      end else begin
        n = notes.pop_front();
        if (n[11:8] < 4'h4) check_val("basic", rd_data, n[7:0]);
        else if (n[11:8] < 4'h7) check_val("fixed", rd_data, n[7:0]);
        else if (n[11:8] == 4'h7) check_val("grp_err", rd_data, n[7:0]);
        else if (n[11:8] < 4'hc) check_val("in_lost", rd_data, n[7:0]);
        else check_val("cnt_lost", rd_data, n[7:0]);
      end
    end
  end

  // random sources; busy is thinned so losses stay sparse
  task automatic rnd_ev();
    logic [31:0] a;
    logic [31:0] b;
    logic [31:0] c;
    a = xrand();
    b = xrand();
    c = xrand();
    basic_rec <= xrand();
    grp_err   <= a[15:8];
    din_evt   <= quiet ? 16'h0000 : a[31:16];
    din_busy  <= b[15:0] & b[31:16] & c[15:0];
    cnt_evt   <= quiet ? 16'h0000 : c[31:16];
    cnt_busy  <= a[15:0] & b[23:8] & c[23:8];
  endtask

  // event cycles, clock enable dropped now and then
  task automatic events(input logic cap);
    @(posedge clk);
    ce       <= (xrand() % 4) != 0;
    diag_evt <= cap;
    rd_req   <= 1'b0;
    rnd_ev();
  endtask

  // back-to-back reads: bytes in order, then random indices; clock enable dropped now and then skips reads
  task automatic read_all();
    logic [31:0] r;
    for (int i = 0; i < 32; i++) begin
      @(posedge clk);
      r = xrand();
      ce       <= r[31:30] != 2'b00;
      diag_evt <= 1'b0;
      rd_req   <= 1'b1;
      rd_addr  <= (i < 16) ? i[3:0] : r[3:0];
      rnd_ev();
    end
    @(posedge clk);
    ce     <= 1'b1;
    rd_req <= 1'b0;
    for (int k = 0; k < 8 && notes.size() != 0; k++) @(posedge clk);
    if (notes.size() != 0) begin
      err_total++;
      $display("BAD read_answers expected 0 seen %0d", notes.size());
      stop_test();
    end
  endtask

  initial begin
    {clk, live, quiet} = 3'b000;
    rs = 32'h0000bac7;
    {err_total, checked} = 0;
    {ce, rst} = 2'b11;
    {diag_evt, rd_req, rd_addr, basic_rec, grp_err} = '0;
    {din_evt, din_busy, cnt_evt, cnt_busy} = '0;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    read_all();
    for (int it = 0; it < 40; it++) begin
      quiet = (it % 4) == 3;
      repeat (4) events(1'b0);
      events(1'b1);
      read_all();
    end
    // second reset in mid-run empties the record again
    @(posedge clk);
    ce  <= 1'b1;
    rst <= 1'b1;
    @(posedge clk);
    rst <= 1'b0;
    read_all();
    stop_test();
  end
endmodule
